/* File: design/dpc_regs.svh */
// Constants for the pin configuration and sample input block
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH
// ****************************************
// Serial configuration register
// ****************************************
`define DPC_CFG_ADDR      7'h00
`define DPC_CFG_RESET     8'h00
`define DPC_BIT_TWOS      0
`define DPC_BIT_PD        1
`define DPC_BIT_CDIFF     2
// ****************************************
// Serial frame layout and sample width
// ****************************************
`define DPC_HDR_BITS      5'h08
`define DPC_FRAME_BITS    5'h10
`define DPC_SAMPLE_W      10
`define DPC_FIFO_DEPTH    8
`endif

/* File: design/dpc_pkg.sv */
// Types shared by the pin configuration and sample input block
`include "dpc_regs.svh"
package dpc_pkg;
    typedef logic [`DPC_SAMPLE_W-1:0] dpc_sample_t;
    typedef enum {ST_IDLE, ST_HDR, ST_DATA, ST_DONE} dpc_spi_st_t;
endpackage : dpc_pkg

/* File: design/dpc_stream_if.sv */
// Valid/ready sample stream between the capture stage and the FIFO
`timescale 1ns/10ps
`default_nettype none
interface dpc_stream_if #(parameter int W = 10);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dpc_stream_if
`default_nettype wire

/* File: design/dpc_fifo.sv */
// Sample FIFO with parameter width and depth
`timescale 1ns/10ps
`default_nettype none
module dpc_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Fill side
    dpc_stream_if.snk wr,
    // Drain side
    output var  logic         out_valid,
    input  wire logic         out_ready,
    output var  logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire           do_wr = wr.valid & wr.ready;
    wire           do_rd = out_valid & out_ready;

    // Honest full and empty flags
    assign wr.ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];

    // Storage
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_q[wp_q] <= wr.data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) wp_q <= wp_q + 1'b1;
            if (do_rd) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : dpc_fifo
`default_nettype wire

/* File: design/dpc_top.sv */
// Pin configuration, serial configuration port and sample input path
// Notes on behaviour
// (R1) Mode pin high selects pin-strap configuration; low selects serial-port configuration.
// (R2) A high level on the mode pin returns serial registers to defaults.
// (R3) Pin mode: format pin low is straight binary, high is twos complement.
// (R4) Pin mode: clock-type pin low single-ended receiver, high differential receiver.
// (R5) Serial mode: clock-type pin is the serial clock.
// (R6) Serial mode: format pin is the bidirectional serial data line.
// (R7) Pin mode: power-down pin high powers down, low runs normally.
// (R8) Serial mode: chip select active low; port ignored while high.
// (R9) Host drives ten-bit sample, MSB on bit 9, LSB on bit 0.
// (R10) True output code and complementary output code are always bitwise complements.
// (R11) Sample captured on rising edge, applied to the core on a later update.
`timescale 1ns/10ps
`default_nettype none
`include "dpc_regs.svh"
module dpc_top
    import dpc_pkg::*;
#(
    parameter int SAMPLE_W   = `DPC_SAMPLE_W,
    parameter int FIFO_DEPTH = `DPC_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                CLOCK,
    input  wire logic                SYS_RST,
    // Sample pins
    input  wire logic [SAMPLE_W-1:0] SAMPLE_DATA,
    output var  logic                SAMPLE_READY,
    // Configuration pins
    input  wire logic                MODE_SEL,
    input  wire logic                CLK_TYPE_SEL_SERIAL_CLK,
    input  wire logic                POWERDOWN_OR_CHIP_SELECT,
    input  wire logic                FORMAT_SDIO_I,
    output var  logic                FORMAT_SDIO_O,
    output var  logic                FORMAT_SDIO_OE,
    // Core controls and codes
    output var  logic                SERIAL_MODE,
    output var  logic                TWOS_COMP,
    output var  logic                POWER_DOWN,
    output var  logic                CLK_DIFF_EN,
    output var  logic                CLK_SE_EN,
    output var  logic [SAMPLE_W-1:0] TRUE_CODE,
    output var  logic [SAMPLE_W-1:0] COMPLEMENT_CODE
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [SAMPLE_W-1:0] smp_s1_q;
    logic [SAMPLE_W-1:0] smp_s2_q;
    logic [3:0]          pin_s1_q;
    logic [3:0]          pin_s2_q;
    logic                sclk_s3_q;
    logic                csn_s3_q;

    // Two flops on every pin before use
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            smp_s1_q  <= '0;
            smp_s2_q  <= '0;
            pin_s1_q  <= 4'h4;    // Pin mode and awake, so no control moves
            pin_s2_q  <= 4'h4;    // before the real pin levels arrive
            sclk_s3_q <= 1'b0;
            csn_s3_q  <= 1'b1;
        end else begin
            smp_s1_q  <= SAMPLE_DATA;
            smp_s2_q  <= smp_s1_q;
            pin_s1_q  <= {POWERDOWN_OR_CHIP_SELECT, MODE_SEL, CLK_TYPE_SEL_SERIAL_CLK, FORMAT_SDIO_I};
            pin_s2_q  <= pin_s1_q;
            sclk_s3_q <= pin_s2_q[1];
            csn_s3_q  <= pin_s2_q[3];
        end
    end

    // Synchronised pin levels
    wire pd_cs_s  = pin_s2_q[3];
    wire mode_s   = pin_s2_q[2];
    wire ctype_s  = pin_s2_q[1];
    wire sdio_s   = pin_s2_q[0];
    wire pin_mode = mode_s;                                // [R1]
    wire sclk_s   = ctype_s;                               // [R5]
    wire csn_s    = pd_cs_s;
    wire cs_act   = ~pin_mode & ~csn_s;                    // [R8]
    wire sclk_ris = cs_act & sclk_s & ~sclk_s3_q;
    wire sclk_fal = cs_act & ~sclk_s & sclk_s3_q;
    wire cs_fall  = ~pin_mode & ~csn_s & csn_s3_q;

    // ****************************************
    // Serial configuration port
    // ****************************************
    dpc_spi_st_t st_q;
    dpc_spi_st_t st_d;
    logic [4:0]  bit_q;
    logic [15:0] sh_q;
    logic [7:0]  tx_q;
    logic [7:0]  cfg_q;
    logic        rd_q;

    // Frame decode
    wire [15:0] sh_nxt   = {sh_q[14:0], sdio_s};           // [R6]
    wire [4:0]  bit_nxt  = bit_q + 5'h01;
    wire        hdr_done = sclk_ris & (st_q == ST_HDR) & (bit_nxt == `DPC_HDR_BITS);
    wire        frm_done = sclk_ris & (st_q == ST_DATA) & (bit_nxt == `DPC_FRAME_BITS);
    wire        addr_hit = (sh_nxt[14:8] == `DPC_CFG_ADDR);
    wire        wr_hit   = frm_done & ~sh_nxt[15] & addr_hit;

    // Next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (cs_fall) st_d = ST_HDR;
            end
            ST_HDR: begin
                if (hdr_done) st_d = ST_DATA;
            end
            ST_DATA: begin
                if (frm_done) st_d = ST_DONE;
            end
            ST_DONE: begin
                st_d = ST_DONE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (~cs_act) st_d = ST_IDLE;                       // [R8]
    end

    // State and bit counter
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_q  <= ST_IDLE;
            bit_q <= '0;
            sh_q  <= '0;
        end else begin
            st_q <= st_d;
            if (st_d == ST_IDLE) begin
                bit_q <= '0;
            end else if (sclk_ris) begin
                bit_q <= bit_nxt;
                sh_q  <= sh_nxt;
            end
        end
    end

    // Read flag and transmit shifter, data changes on falling edges
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_q <= 1'b0;
            tx_q <= '0;
        end else if (hdr_done) begin
            rd_q <= sh_nxt[7] & (sh_nxt[6:0] == `DPC_CFG_ADDR);
            tx_q <= cfg_q;
        end else if (sclk_fal & (st_q == ST_DATA)) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end else if (st_q == ST_IDLE) begin
            rd_q <= 1'b0;
        end
    end

    // Data line driver, enabled only during a read data phase
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            FORMAT_SDIO_O  <= 1'b0;
            FORMAT_SDIO_OE <= 1'b0;
        end else begin
            FORMAT_SDIO_OE <= cs_act & rd_q & (st_q == ST_DATA);   // [R6]
            if (sclk_fal & (st_q == ST_DATA)) FORMAT_SDIO_O <= tx_q[7];
        end
    end

    // Configuration register, held at default while the mode pin is high
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cfg_q <= `DPC_CFG_RESET;
        end else if (pin_mode) begin
            cfg_q <= `DPC_CFG_RESET;                       // [R2]
        end else if (wr_hit) begin
            cfg_q <= sh_nxt[7:0];
        end
    end

    // ****************************************
    // Mode selection of controls
    // ****************************************
    wire twos_d  = pin_mode ? sdio_s  : cfg_q[`DPC_BIT_TWOS];   // [R3]
    wire cdiff_d = pin_mode ? ctype_s : cfg_q[`DPC_BIT_CDIFF];  // [R4]
    wire pd_d    = pin_mode ? pd_cs_s : cfg_q[`DPC_BIT_PD];     // [R7]

    // Control outputs
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            SERIAL_MODE <= 1'b0;
            TWOS_COMP   <= 1'b0;
            POWER_DOWN  <= 1'b0;
            CLK_DIFF_EN <= 1'b0;
            CLK_SE_EN   <= 1'b1;
        end else begin
            SERIAL_MODE <= ~pin_mode;                      // [R1]
            TWOS_COMP   <= twos_d;
            POWER_DOWN  <= pd_d;
            CLK_DIFF_EN <= cdiff_d;                        // [R4]
            CLK_SE_EN   <= ~cdiff_d;
        end
    end

    // ****************************************
    // Sample path
    // ****************************************
    dpc_stream_if #(.W(SAMPLE_W)) cap_if ();
    logic                fifo_valid;
    logic [SAMPLE_W-1:0] fifo_data;
    wire                 core_ready = ~POWER_DOWN;

    // Every update edge offers the synchronised word, MSB on bit 9
    assign cap_if.valid = 1'b1;                            // [R9]
    assign cap_if.data  = smp_s2_q;                        // [R11]

    dpc_fifo #(.W(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (CLOCK),
        .rst       (SYS_RST),
        .wr        (cap_if.snk),
        .out_valid (fifo_valid),
        .out_ready (core_ready),
        .out_data  (fifo_data)
    );

    // Twos complement becomes offset binary by flipping the sign bit
    wire [SAMPLE_W-1:0] code_d = TWOS_COMP ?
        {~fifo_data[SAMPLE_W-1], fifo_data[SAMPLE_W-2:0]} : fifo_data;   // [R3]

    // Core code registers, stalled during power-down
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            TRUE_CODE       <= '0;
            COMPLEMENT_CODE <= '1;
            SAMPLE_READY    <= 1'b0;
        end else begin
            SAMPLE_READY <= cap_if.ready;
            if (fifo_valid & core_ready) begin
                TRUE_CODE       <= code_d;                 // [R11]
                COMPLEMENT_CODE <= ~code_d;                // [R10]
            end
        end
    end
endmodule : dpc_top
`default_nettype wire

/* File: verif/dpc_host_model.sv */
// Serial host model for the shared configuration pins
`timescale 1ns/10ps
`default_nettype none
module dpc_host_model (
    // Clock and resolved data line
    input  wire logic clk,
    input  wire logic sdio_w,
    // Serial pins
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic sd_o
);
    logic drv = 1'b0;
    logic sd  = 1'b0;
    // A released line shows the inverse of the last bit, never a stale copy
    assign sd_o = drv ? sd : ~sd;
    // Serial clock stands low and select stands high outside frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // One frame, MSB first, half period of five clocks to suit the oversampler
    task automatic xfer(input logic [15:0] f, output logic [7:0] q);
        q = 8'h00;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            drv <= (i > 7) || !f[15];
            sd  <= f[i];
            repeat (5) @(posedge clk);
            if (i < 8) q[i] = sdio_w;
            sclk <= 1'b1;
            repeat (5) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (5) @(posedge clk);
        cs_n <= 1'b1;
        drv  <= 1'b0;
    endtask : xfer
endmodule : dpc_host_model
`default_nettype wire

/* File: verif/dpc_top_asserts.sv */
// Port assertions for the pin configuration block
`timescale 1ns/10ps
`default_nettype none
module dpc_top_asserts #(
    parameter int SAMPLE_W = 10
) (
    // Clock, reset and pins
    input wire logic                CLOCK,
    input wire logic                SYS_RST,
    input wire logic                MODE_SEL,
    input wire logic                CLK_TYPE_SEL_SERIAL_CLK,
    input wire logic                POWERDOWN_OR_CHIP_SELECT,
    input wire logic                FORMAT_SDIO_I,
    input wire logic                FORMAT_SDIO_OE,
    input wire logic                SAMPLE_READY,
    // Core controls and codes
    input wire logic                SERIAL_MODE,
    input wire logic                TWOS_COMP,
    input wire logic                POWER_DOWN,
    input wire logic                CLK_DIFF_EN,
    input wire logic                CLK_SE_EN,
    input wire logic [SAMPLE_W-1:0] TRUE_CODE,
    input wire logic [SAMPLE_W-1:0] COMPLEMENT_CODE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    chk_code_compl: assert property (COMPLEMENT_CODE == ~TRUE_CODE)
        else $error("complement code wrong");
    chk_recv_one: assert property (CLK_SE_EN != CLK_DIFF_EN)
        else $error("clock receivers not exclusive");
    chk_pin_mode: assert property (MODE_SEL [*6] |=> !SERIAL_MODE)
        else $error("serial mode while pin high");
    chk_serial_mode: assert property (!MODE_SEL [*6] |=> SERIAL_MODE)
        else $error("pin mode while pin low");
    chk_pin_format: assert property ((MODE_SEL && $stable(FORMAT_SDIO_I)) [*6] |=> TWOS_COMP == $past(FORMAT_SDIO_I))
        else $error("format strap not followed");
    chk_pin_clock: assert property ((MODE_SEL && $stable(CLK_TYPE_SEL_SERIAL_CLK)) [*6]
        |=> CLK_DIFF_EN == $past(CLK_TYPE_SEL_SERIAL_CLK))
        else $error("clock strap not followed");
    chk_pin_sleep: assert property ((MODE_SEL && $stable(POWERDOWN_OR_CHIP_SELECT)) [*6]
        |=> POWER_DOWN == $past(POWERDOWN_OR_CHIP_SELECT))
        else $error("sleep strap not followed");
    chk_cs_idle: assert property (POWERDOWN_OR_CHIP_SELECT [*6] |=> !FORMAT_SDIO_OE)
        else $error("data driven while deselected");
    chk_sleep_hold: assert property (POWER_DOWN [*3] |-> $stable(TRUE_CODE))
        else $error("code moved in power down");
    // Main scenarios reached
    cover property (SERIAL_MODE && FORMAT_SDIO_OE);
    cover property (POWER_DOWN && !SAMPLE_READY);
    cover property (SERIAL_MODE && TWOS_COMP);
    cover property (SERIAL_MODE && CLK_DIFF_EN);
endmodule : dpc_top_asserts
bind dpc_top dpc_top_asserts #(.SAMPLE_W(SAMPLE_W)) dpc_top_asserts_i (
    .CLOCK, .SYS_RST, .MODE_SEL, .CLK_TYPE_SEL_SERIAL_CLK, .POWERDOWN_OR_CHIP_SELECT,
    .FORMAT_SDIO_I, .FORMAT_SDIO_OE, .SAMPLE_READY, .SERIAL_MODE, .TWOS_COMP,
    .POWER_DOWN, .CLK_DIFF_EN, .CLK_SE_EN, .TRUE_CODE, .COMPLEMENT_CODE
);
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the pin configuration block
`timescale 1ns/10ps
`default_nettype none
module testbench
    import dpc_pkg::*;
;
    typedef struct packed {logic f; logic c; dpc_sample_t d; logic t; logic x; dpc_sample_t e;} dpc_row_t;
    logic        clk, rst, mode, fmt_s, ct_s, pd_s, sclk, cs_n, h_sd;
    logic        sd_o, sd_oe, ser, twos, pdn, diff, se, rdy;
    dpc_sample_t smp, tc, cc;
    logic [7:0]  q;
    int          fails, total_checks, i;
    dpc_row_t    rows [5];
    // Shared pins follow the mode and the driver enables
    wire fmt_w = sd_oe ? sd_o : (mode ? fmt_s : h_sd);
    wire ct_w  = mode ? ct_s : sclk;
    wire pd_w  = mode ? pd_s : cs_n;
    dpc_top #(.FIFO_DEPTH(8)) dpc_top_i (
        .CLOCK(clk), .SYS_RST(rst), .SAMPLE_DATA(smp), .SAMPLE_READY(rdy),
        .MODE_SEL(mode), .CLK_TYPE_SEL_SERIAL_CLK(ct_w), .POWERDOWN_OR_CHIP_SELECT(pd_w),
        .FORMAT_SDIO_I(fmt_w), .FORMAT_SDIO_O(sd_o), .FORMAT_SDIO_OE(sd_oe),
        .SERIAL_MODE(ser), .TWOS_COMP(twos), .POWER_DOWN(pdn), .CLK_DIFF_EN(diff),
        .CLK_SE_EN(se), .TRUE_CODE(tc), .COMPLEMENT_CODE(cc)
    );
    dpc_host_model dpc_host_model_i (.clk(clk), .sdio_w(fmt_w), .sclk(sclk), .cs_n(cs_n), .sd_o(h_sd));
    // Compare one result, flags zero-extended
    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Wait n edges and let their updates land
    task automatic t(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : t
    // Report and end the run
    task automatic give_verdict;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        smp = 10'h000;
        mode = 1'b1;
        fmt_s = 1'b0;
        ct_s = 1'b0;
        pd_s = 1'b0;
        fails = 0;
        total_checks = 0;
        rows = '{'{1'h0, 1'h0, 10'h3FF, 1'h0, 1'h0, 10'h3FF}, '{1'h1, 1'h1, 10'h000, 1'h1, 1'h1, 10'h200},
                 '{1'h1, 1'h0, 10'h155, 1'h1, 1'h0, 10'h355}, '{1'h0, 1'h1, 10'h2AA, 1'h0, 1'h1, 10'h2AA},
                 '{1'h1, 1'h1, 10'h3FF, 1'h1, 1'h1, 10'h1FF}};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Pin-strap rows
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            fmt_s <= rows[i].f;
            ct_s  <= rows[i].c;
            smp   <= rows[i].d;
            t(12);
            chk(twos, rows[i].t);
            chk(diff, rows[i].x);
            chk(se, !rows[i].x);
            chk(tc, rows[i].e);
            chk(cc, ~rows[i].e);
        end
        // Pipeline latency of one word
        @(posedge clk);
        smp <= 10'h0CC;
        t(3);
        chk(tc, 10'h1FF);
        t(1);
        chk(tc, 10'h2CC);
        // Power down stalls, buffer fills, then drains
        @(posedge clk);
        pd_s <= 1'b1;
        t(6);
        chk(pdn, 1'b1);
        @(posedge clk);
        smp <= 10'h001;
        t(14);
        chk(tc, 10'h2CC);
        chk(rdy, 1'b0);
        @(posedge clk);
        pd_s <= 1'b0;
        for (i = 0; i < 40 && rdy !== 1'b1; i++) t(1);
        if (rdy !== 1'b1) begin
            fails++;
            give_verdict();
        end
        t(20);
        chk(tc, 10'h201);
        // Serial mode: write, read back
        @(posedge clk);
        mode <= 1'b0;
        t(8);
        chk(ser, 1'b1);
        dpc_host_model_i.xfer(16'h0003, q);
        t(8);
        chk({twos, pdn, diff, se}, 4'hD);
        dpc_host_model_i.xfer(16'h8000, q);
        chk(q, 8'h03);
        // Read of an unknown address leaves the line to the host
        t(4);
        dpc_host_model_i.xfer(16'h8100, q);
        chk(q, 8'hFF);
        // Differential receiver chosen through the serial port
        t(4);
        dpc_host_model_i.xfer(16'h0004, q);
        t(8);
        chk({twos, pdn, diff, se}, 4'h2);
        // Mode pulse returns the configuration to defaults
        @(posedge clk);
        mode <= 1'b1;
        t(6);
        @(posedge clk);
        mode <= 1'b0;
        t(8);
        chk({twos, pdn, diff, se}, 4'h1);
        // Second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        t(2);
        chk(tc, 10'h000);
        chk(cc, 10'h3FF);
        @(posedge clk);
        rst <= 1'b0;
        t(8);
        chk(ser, 1'b1);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
